// file: hw/bll_loop.sv
/*
 black level feedback loop with a wishbone classic register slave.
 assumes samples and black-pixel flags are synchronous to CLOCK_IN.
*/
// Register access over Wishbone is this design's own decision.
// Notes on behaviour
// - nine-bit offset: low byte at index 0Dh, top bit at bit 0 of 0Eh, both RW.
// - after reset the high location reads 01h and the low 00h, value 256.
// - offset stays within 0 to 511; 0 most negative, 511 most positive.
// - while enabled, black pixels steer the converter output toward code 64.
// - bits 7:6 of 0Fh pick weight 1x, 2x, 4x or 8x.
// - each black pixel error is multiplied by the weight before summing.
// - bits 5:0 of 0Fh give how many black pixels are summed per update.
// - correction divided by 2048,1024,512,256 for fixed gain x1,x2,x4,x8/none; halved when range is 0.
`timescale 1ns/1ps
module bll_loop (
	// clock and reset
	input wire logic CLOCK_IN,
	input wire logic RST_N_IN,
	// wishbone slave
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [31:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	// converter samples
	input wire logic [bll_pkg::SAMPLE_W-1:0] SAMPLE_IN,
	input wire logic SAMPLE_VALID_IN,
	input wire logic BLACK_PIXEL_IN,
	// offset to the analog path
	output logic [8:0] OFFSET_OUT
);
	import bll_pkg::*;

	logic [8:0] acc;
	logic [8:0] next_acc;
	logic [7:0] wgt_cnt;
	logic [7:0] next_wgt_cnt;
	logic [7:0] loop_ctrl;
	logic [7:0] next_loop_ctrl;
	logic signed [SUM_W-1:0] sum;
	logic signed [SUM_W-1:0] next_sum;
	logic [5:0] pix_cnt;
	logic [5:0] next_pix_cnt;
	logic ack;
	logic next_ack;
	logic [31:0] rdata;
	logic [31:0] next_rdata;

	logic req;
	logic hit;
	logic [7:0] idx;
	logic wr_low;
	logic wr_high;
	logic wr_cfg;
	logic rd_req;
	logic loop_en;
	logic pixel;
	logic [1:0] wgt_sel;
	logic [5:0] clamp_len;
	logic [2:0] fixed_gain;
	logic [3:0] shift;
	logic signed [SAMPLE_W:0] err;
	logic signed [SUM_W-1:0] weighted;
	logic signed [SUM_W-1:0] sum_with_pix;
	logic [8:0] stepped;

	assign req = WB_CYC_IN & WB_STB_IN & ~ack;
	assign idx = WB_ADR_IN[9:2];
	assign hit = (WB_ADR_IN[31:10] == 22'h000000);
	assign wr_low = req & WB_WE_IN & WB_SEL_IN[0] & hit & (idx == IDX_OFS_LOW);
	assign wr_high = req & WB_WE_IN & WB_SEL_IN[0] & hit & (idx == IDX_OFS_HIGH);
	assign wr_cfg = req & WB_WE_IN & WB_SEL_IN[0] & hit;
	assign rd_req = req & ~WB_WE_IN & hit;
	assign loop_en = loop_ctrl[CTRL_EN_BIT];
	assign pixel = loop_en & SAMPLE_VALID_IN & BLACK_PIXEL_IN;
	assign wgt_sel = wgt_cnt[WGT_LSB +: 2];
	assign clamp_len = wgt_cnt[CNT_LSB +: 6];
	assign fixed_gain = loop_ctrl[CTRL_FG_LSB +: 3];

	bll_sat_step u_step (
		.acc_in(acc),
		.sum_in(sum_with_pix),
		.shift_in(shift),
		.acc_out(stepped)
	);

	// loop arithmetic
	always_comb begin
		err = $signed(BLACK_TARGET) - $signed({1'b0, SAMPLE_IN});
		weighted = $signed({{(SUM_W-SAMPLE_W-1){err[SAMPLE_W]}}, err}) <<< wgt_sel;
		sum_with_pix = sum + weighted;
		unique case (fixed_gain)
			FG_X1: shift = BASE_SHIFT + 4'h3;
			FG_X2: shift = BASE_SHIFT + 4'h2;
			FG_X4: shift = BASE_SHIFT + 4'h1;
			default: shift = BASE_SHIFT;
		endcase
		if (!loop_ctrl[CTRL_RANGE_BIT]) begin
			shift = shift + 4'h1;
		end
	end

	// bus answer
	always_comb begin
		next_ack = req;
		next_rdata = 32'h00000000;
		if (rd_req) begin
			unique case (idx)
				IDX_OFS_LOW: next_rdata = {24'h000000, acc[7:0]};
				IDX_OFS_HIGH: next_rdata = {31'h00000000, acc[8]};
				IDX_WGT_CNT: next_rdata = {24'h000000, wgt_cnt};
				IDX_LOOP_CTRL: next_rdata = {24'h000000, loop_ctrl};
				default: next_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			ack <= 1'b0;
			rdata <= 32'h00000000;
		end else begin
			ack <= next_ack;
			rdata <= next_rdata;
		end
	end

	// configuration registers
	always_comb begin
		next_wgt_cnt = wgt_cnt;
		next_loop_ctrl = loop_ctrl;
		if (wr_cfg && idx == IDX_WGT_CNT) begin
			next_wgt_cnt = WB_DAT_IN[7:0];
		end
		if (wr_cfg && idx == IDX_LOOP_CTRL) begin
			next_loop_ctrl = {3'h0, WB_DAT_IN[4:0]};
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			wgt_cnt <= WGT_CNT_RST;
			loop_ctrl <= LOOP_CTRL_RST;
		end else begin
			wgt_cnt <= next_wgt_cnt;
			loop_ctrl <= next_loop_ctrl;
		end
	end

	// loop accumulator
	always_comb begin
		next_acc = acc;
		next_sum = sum;
		next_pix_cnt = pix_cnt;
		if (!loop_en || clamp_len == 6'h00) begin
			next_sum = '0;
			next_pix_cnt = 6'h00;
		end else if (pixel) begin
			if (pix_cnt + 6'h01 == clamp_len) begin
				next_acc = stepped;
				next_sum = '0;
				next_pix_cnt = 6'h00;
			end else begin
				next_sum = sum_with_pix;
				next_pix_cnt = pix_cnt + 6'h01;
			end
		end
		if (wr_low || wr_high) begin
			next_sum = '0;
			next_pix_cnt = 6'h00;
		end
		if (wr_low) begin
			next_acc[7:0] = WB_DAT_IN[7:0];
		end
		if (wr_high) begin
			next_acc[8] = WB_DAT_IN[0];
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			acc <= OFS_RST;
			sum <= '0;
			pix_cnt <= 6'h00;
			OFFSET_OUT <= OFS_RST;
		end else begin
			acc <= next_acc;
			sum <= next_sum;
			pix_cnt <= next_pix_cnt;
			OFFSET_OUT <= next_acc;
		end
	end

	assign WB_ACK_OUT = ack;
	assign WB_DAT_OUT = rdata;
endmodule

// file: hw/bll_pkg.sv
/*
 black level loop package: register indices, field layout, reset values, loop constants.
 assumes a 32-bit wishbone bus where register index n sits at byte address 4*n.
*/
package bll_pkg;
	// register indices
	localparam logic [7:0] IDX_OFS_LOW = 8'h0d;
	localparam logic [7:0] IDX_OFS_HIGH = 8'h0e;
	localparam logic [7:0] IDX_WGT_CNT = 8'h0f;
	localparam logic [7:0] IDX_LOOP_CTRL = 8'h14;
	// field layout
	localparam int WGT_LSB = 6;
	localparam int CNT_LSB = 0;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_RANGE_BIT = 1;
	localparam int CTRL_FG_LSB = 2;
	// reset values
	localparam logic [8:0] OFS_RST = 9'h100;
	localparam logic [7:0] WGT_CNT_RST = 8'h0a;
	localparam logic [7:0] LOOP_CTRL_RST = 8'h03;
	// widths and loop constants
	localparam int SAMPLE_W = 13;
	localparam int SUM_W = 24;
	localparam logic [8:0] OFS_MAX = 9'h1ff;
	localparam logic [SAMPLE_W:0] BLACK_TARGET = 14'h0040;
	localparam logic [3:0] BASE_SHIFT = 4'h8;
	// fixed gain codes
	localparam logic [2:0] FG_NONE = 3'h0;
	localparam logic [2:0] FG_X1 = 3'h1;
	localparam logic [2:0] FG_X2 = 3'h2;
	localparam logic [2:0] FG_X4 = 3'h3;
	localparam logic [2:0] FG_X8 = 3'h4;
endpackage

// file: hw/bll_sat_step.sv
/*
 saturating accumulator step: adds a scaled signed correction to the 9-bit offset.
 assumes the caller registers the result.
*/
`timescale 1ns/1ps
module bll_sat_step (
	// operands
	input wire logic [8:0] acc_in,
	input wire logic signed [bll_pkg::SUM_W-1:0] sum_in,
	input wire logic [3:0] shift_in,
	// result
	output logic [8:0] acc_out
);
	import bll_pkg::*;
	logic signed [SUM_W-1:0] delta;
	logic signed [SUM_W:0] total;
	always_comb begin
		delta = sum_in >>> shift_in;
		total = $signed({{(SUM_W-8){1'b0}}, acc_in}) + $signed({delta[SUM_W-1], delta});
		if (total < 0) begin
			acc_out = 9'h000;
		end else if (total > $signed({{(SUM_W-8){1'b0}}, OFS_MAX})) begin
			acc_out = OFS_MAX;
		end else begin
			acc_out = total[8:0];
		end
	end
endmodule

// file: verif/bll_loop_props.sv
/*
 port checker for the black level loop.
 assumes one clock domain and a synchronous active low reset.
*/
`timescale 1ns/1ps
module bll_props (
	// clock and reset
	input wire logic CLOCK_IN,
	input wire logic RST_N_IN,
	// bus and samples
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [31:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	input wire logic [31:0] WB_DAT_OUT,
	input wire logic WB_ACK_OUT,
	input wire logic SAMPLE_VALID_IN,
	input wire logic BLACK_PIXEL_IN,
	input wire logic [8:0] OFFSET_OUT
);
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (!RST_N_IN);
	logic req;
	logic wr;
	assign req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
	assign wr = req && WB_WE_IN && WB_SEL_IN[0];
	chk_ack_next: assert property (req |=> WB_ACK_OUT) else $error("ack late");
	chk_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack held");
	chk_rst_mid: assert property ($rose(RST_N_IN) |-> OFFSET_OUT == 9'h100) else $error("reset offset");
	chk_idle_hold: assert property (!(SAMPLE_VALID_IN && BLACK_PIXEL_IN) && !wr |=> $stable(OFFSET_OUT))
		else $error("offset moved");
	chk_dat_idle: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0) else $error("data idle");
	chk_dat_upper: assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:9] == 23'h0) else $error("data upper");
	chk_wr_low: assert property (wr && WB_ADR_IN == 32'h34 |=> OFFSET_OUT[7:0] == $past(WB_DAT_IN[7:0]))
		else $error("low write");
	chk_wr_high: assert property (wr && WB_ADR_IN == 32'h38 |=> OFFSET_OUT[8] == $past(WB_DAT_IN[0]))
		else $error("high write");
	cover property (wr);
	cover property (WB_ACK_OUT && !WB_WE_IN);
	cover property (SAMPLE_VALID_IN && BLACK_PIXEL_IN ##1 $changed(OFFSET_OUT));
endmodule
bind bll_loop bll_props i_props (.CLOCK_IN, .RST_N_IN, .WB_CYC_IN, .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN,
	.WB_SEL_IN, .WB_DAT_IN, .WB_DAT_OUT, .WB_ACK_OUT, .SAMPLE_VALID_IN, .BLACK_PIXEL_IN, .OFFSET_OUT);

// file: verif/bll_loop_test.sv
/*
 self-checking bench for the black level loop.
 assumes the bll_pkg package and a one-cycle bus answer.
*/
`timescale 1ns/1ps
module bll_loop_test;
	import bll_pkg::*;
	logic CLOCK_IN = 0, RST_N_IN = 0, cyc = 0, stb = 0, we = 0, vld = 0, blk = 0, ack;
	logic [31:0] adr = 0, wd = 0, rd, dout;
	logic [SAMPLE_W-1:0] smp = 0;
	logic [8:0] ofs;
	int fail_count = 0, check_count = 0;
	bll_loop i_dut (.CLOCK_IN, .RST_N_IN, .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
		.WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(wd), .WB_DAT_OUT(dout), .WB_ACK_OUT(ack),
		.SAMPLE_IN(smp), .SAMPLE_VALID_IN(vld), .BLACK_PIXEL_IN(blk), .OFFSET_OUT(ofs));
	initial forever #5 CLOCK_IN = ~CLOCK_IN;
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wb(logic w, logic [7:0] a, logic [7:0] d);
		@(posedge CLOCK_IN);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= {22'h0, a, 2'h0};
		wd <= {24'h0, d};
		do @(posedge CLOCK_IN); while (ack !== 1'b1);
		rd = dout;
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic rdchk(logic [7:0] a, logic [31:0] e);
		wb(0, a, 8'h0);
		chk("rdata", e, rd);
	endtask
	task automatic setofs(logic [8:0] v);
		wb(1, 8'h0d, v[7:0]);
		wb(1, 8'h0e, {7'h0, v[8]});
	endtask
	task automatic pix(logic [SAMPLE_W-1:0] s, int n, logic [8:0] e);
		@(posedge CLOCK_IN);
		smp <= s;
		vld <= 1;
		blk <= 1;
		repeat (n) @(posedge CLOCK_IN);
		vld <= 0;
		blk <= 0;
		#1 chk("offset", e, ofs);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		fail_count++;
		test_done;
	end
	task automatic test_reset;
		chk("offset", 32'h100, ofs);
		rdchk(8'h0d, 32'h0);
		rdchk(8'h0e, 32'h1);
		rdchk(8'h0f, 32'h0a);
		rdchk(8'h14, 32'h03);
		rdchk(8'h80, 32'h0);
		$display("reset test done");
	endtask
	task automatic test_weight;
		for (int w = 0; w < 4; w++) begin
			setofs(9'h100);
			wb(1, 8'h0f, {w[1:0], 6'h01});
			rdchk(8'h0f, {24'h0, w[1:0], 6'h01});
			pix(13'h0, 1, 9'h100 + 9'((64 << w) >> 8));
		end
		$display("weight test done");
	endtask
	task automatic test_count;
		setofs(9'h100);
		wb(1, 8'h0f, 8'hc2);
		pix(13'h0, 1, 9'h100);
		pix(13'h0, 1, 9'h104);
		pix(13'h40, 2, 9'h104);
		$display("count test done");
	endtask
	task automatic test_saturation;
		wb(1, 8'h0f, 8'hc1);
		setofs(9'h1ff);
		pix(13'h0, 1, 9'h1ff);
		setofs(9'h0);
		pix(13'h1fff, 1, 9'h0);
		$display("saturation test done");
	endtask
	task automatic test_gain;
		wb(1, 8'h14, 8'h01);
		setofs(9'h100);
		pix(13'h0, 1, 9'h101);
		wb(1, 8'h0f, 8'hc8);
		for (int g = 1; g < 5; g++) begin
			wb(1, 8'h14, {3'h0, g[2:0], 2'h3});
			setofs(9'h100);
			pix(13'h0, 8, 9'h100 + 9'(1 << g));
		end
		$display("gain test done");
	endtask
	task automatic test_disable;
		wb(1, 8'h14, 8'h02);
		pix(13'h0, 1, 9'h110);
		setofs(9'h155);
		rdchk(8'h0d, 32'h55);
		rdchk(8'h0e, 32'h1);
		$display("disable test done");
	endtask
	initial begin
		repeat (20) @(posedge CLOCK_IN);
		RST_N_IN <= 1;
		test_reset;
		test_weight;
		test_count;
		test_saturation;
		test_gain;
		test_disable;
		test_done;
	end
endmodule
